// >>> src/rsc_pkg.sv
// Constants and types for the reset source controller
package rsc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] REG_SRC = 4'h0;
	localparam logic [ADDR_W-1:0] REG_MON = 4'h4;
	localparam logic [ADDR_W-1:0] REG_LIVE = 4'h8;
	localparam int SRC_MON_SEL = 0;
	localparam int SRC_POR = 1;
	localparam int SRC_MCD = 2;
	localparam int SRC_COMP = 3;
	localparam int SRC_SW = 4;
	localparam int SRC_FERR = 5;
	localparam int SRC_WDT = 6;
	localparam int SRC_PIN = 7;
	localparam int MON_EN_BIT = 0;
	localparam int LIVE_SUPPLY_LOW = 0;
	localparam int LIVE_COMP_BELOW = 1;
	localparam int LIVE_PIN_LOW = 2;
	localparam int LIVE_IN_RESET = 3;
	localparam int LIVE_PIN_DRIVE = 4;
	localparam logic [7:0] PORT_RESET_VAL = 8'hFF;
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [15:0] USER_TOP = 16'h1FFF;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int POR_DELAY_NS = 300000;
	localparam int MIN_RESET_NS = 1000;
	localparam int CNT_W = 12;
	localparam logic [CNT_W-1:0] POR_DELAY_CYC = CNT_W'((POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] MIN_RESET_CYC = CNT_W'((MIN_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

	typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_DELAY} rsc_state_t;
	typedef enum logic [2:0] {
		CAUSE_POR, CAUSE_SUPPLY, CAUSE_PIN, CAUSE_MCD,
		CAUSE_COMP, CAUSE_WDT, CAUSE_FLASH, CAUSE_SW
	} rsc_cause_t;
	typedef enum logic [1:0] {FOP_READ, FOP_WRITE, FOP_ERASE, FOP_FETCH} rsc_flash_op_t;

	typedef struct packed {
		logic valid;
		rsc_flash_op_t op;
		logic [15:0] addr;
		logic secure_block;
	} rsc_flash_req_t;

	typedef struct packed {
		logic grant;
		rsc_flash_op_t op;
	} rsc_flash_ans_t;

	typedef struct packed {
		logic start;
		logic wdt_enable;
		logic clk_internal;
		logic [15:0] pc;
	} rsc_exit_t;
endpackage : rsc_pkg

// >>> src/rsc_reset_source_controller.sv
// Reset source controller: merges reset sources, records cause, Avalon-MM registers
// Functional notes
// - In reset: core halted, registers at reset values, pins known, interrupts and timers off.
// - Data memory untouched by reset; stack pointer reinitialised by the core.
// - Port latches forced to all ones, open-drain low drive, weak pullups always on.
// - Power-on and supply resets drive the reset pin low while in reset.
// - Exit: program counter cleared, watchdog enabled, internal oscillator, fetch from zero.
// - Power-on and supply resets set power-on flag bit 1; other sources clear it.
// - Power-on leaves supply monitor enabled and selected.
// - Enabled selected monitor holds reset while supply is low, releases on recovery.
// - After a supply reset the power-on flag reads one.
// - Supply reset exit skips the power-on release delay.
// - No reset changes monitor enable or selection.
// - Flash write or erase is dropped while monitor is disabled.
// - Selecting an unsettled monitor may reset; software waits unless flash routines exist.
// - External low on reset pin resets; pin flag set on exit.
// - Missing clock timeout resets, flag one after it, pin not driven.
// - Writing the missing-clock bit enables or disables the detector.
// - Enabled comparator below condition resets, flag one after it, pin not driven.
// - Watchdog timeout resets and sets watchdog flag, pin not driven.
// - Illegal or secured flash access resets and sets flash error flag.
// - Writing the software bit resets; flag reads one after.
//
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
module rsc_reset_source_controller (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic CE,
	input wire logic [rsc_pkg::ADDR_W-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [rsc_pkg::DATA_W-1:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [rsc_pkg::DATA_W-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic RST_PIN_N_IN,
	output logic RST_PIN_N_OUT,
	output logic RST_PIN_N_OE_N,
	input wire logic SUPPLY_LOW,
	input wire logic MCD_TIMEOUT,
	input wire logic COMP_BELOW,
	input wire logic WDT_TIMEOUT,
	input wire rsc_pkg::rsc_flash_req_t FLASH_REQ,
	output rsc_pkg::rsc_flash_ans_t FLASH_ANS,
	output logic CORE_RST,
	output logic PORT_FORCE,
	output logic [7:0] PORT_LATCH,
	output logic WEAK_PULLUP_EN,
	output rsc_pkg::rsc_exit_t EXIT
);
	import rsc_pkg::*;

	rsc_state_t state_r;
	rsc_state_t state_nxt;
	rsc_cause_t cause_r;
	rsc_cause_t cause_nxt;
	rsc_cause_t trip_cause;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic exit_now;
	logic trip;
	logic hold_active;
	logic mon_en_r;
	logic mon_sel_r;
	logic mcd_en_r;
	logic comp_en_r;
	logic sw_req_r;
	logic por_f_r;
	logic pin_f_r;
	logic mcd_f_r;
	logic comp_f_r;
	logic wdt_f_r;
	logic ferr_f_r;
	logic sw_f_r;
	logic pin_low;
	logic supply_trip;
	logic flash_bad;
	logic flash_legal;
	logic bus_req;
	logic bus_do;
	logic wr_src;
	logic wr_mon;
	logic drive_nxt;
	logic [7:0] flag_set;
	logic [DATA_W-1:0] rd_nxt;

	// Source qualification
	assign pin_low = ~RST_PIN_N_IN & RST_PIN_N_OE_N;
	assign supply_trip = mon_en_r & mon_sel_r & SUPPLY_LOW;
	assign flash_legal = (FLASH_REQ.addr <= USER_TOP) & ~FLASH_REQ.secure_block;
	assign flash_bad = FLASH_REQ.valid & ~flash_legal;

	// Bus decode
	assign bus_req = AVS_READ | AVS_WRITE;
	assign bus_do = bus_req & ~AVS_WAITREQUEST;
	assign wr_src = bus_do & AVS_WRITE & AVS_BYTEENABLE[0] & (AVS_ADDRESS == REG_SRC);
	assign wr_mon = bus_do & AVS_WRITE & AVS_BYTEENABLE[0] & (AVS_ADDRESS == REG_MON);

	// Priority among simultaneous sources
	always_comb begin
		trip = 1'b1;
		trip_cause = CAUSE_SUPPLY;
		if (supply_trip) begin
			trip_cause = CAUSE_SUPPLY;
		end else if (pin_low) begin
			trip_cause = CAUSE_PIN;
		end else if (mcd_en_r & MCD_TIMEOUT) begin
			trip_cause = CAUSE_MCD;
		end else if (comp_en_r & COMP_BELOW) begin
			trip_cause = CAUSE_COMP;
		end else if (WDT_TIMEOUT) begin
			trip_cause = CAUSE_WDT;
		end else if (flash_bad) begin
			trip_cause = CAUSE_FLASH;
		end else if (sw_req_r) begin
			trip_cause = CAUSE_SW;
		end else begin
			trip = 1'b0;
		end
	end

	// Level sources keep the device in reset while still active
	always_comb begin
		case (cause_r)
			CAUSE_POR: hold_active = SUPPLY_LOW;
			CAUSE_SUPPLY: hold_active = SUPPLY_LOW;
			CAUSE_PIN: hold_active = ~RST_PIN_N_IN;
			CAUSE_COMP: hold_active = COMP_BELOW;
			default: hold_active = 1'b0;
		endcase
	end

	// Reset sequencer next state
	always_comb begin
		state_nxt = state_r;
		cause_nxt = cause_r;
		cnt_nxt = cnt_r;
		exit_now = 1'b0;
		case (state_r)
			ST_RUN: begin
				if (trip) begin
					state_nxt = ST_HOLD;
					cause_nxt = trip_cause;
					cnt_nxt = MIN_RESET_CYC;
				end
			end
			ST_HOLD: begin
				if (cnt_r != CNT_ZERO) begin
					cnt_nxt = cnt_r - CNT_ONE;
				end else if (!hold_active) begin
					if (cause_r == CAUSE_POR) begin
						state_nxt = ST_DELAY;
						cnt_nxt = POR_DELAY_CYC;
					end else begin
						state_nxt = ST_RUN;
						exit_now = 1'b1;
					end
				end
			end
			ST_DELAY: begin
				if (cnt_r != CNT_ZERO) begin
					cnt_nxt = cnt_r - CNT_ONE;
				end else begin
					state_nxt = ST_RUN;
					exit_now = 1'b1;
				end
			end
			default: begin
				state_nxt = ST_HOLD;
				cause_nxt = CAUSE_POR;
				cnt_nxt = MIN_RESET_CYC;
			end
		endcase
	end

	// Reset pin driven only for power-on and supply causes
	always_comb begin
		drive_nxt = 1'b0;
		if (state_nxt != ST_RUN) begin
			case (cause_nxt)
				CAUSE_POR: drive_nxt = 1'b1;
				CAUSE_SUPPLY: drive_nxt = 1'b1;
				default: drive_nxt = 1'b0;
			endcase
		end
	end

	// Sequencer state
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_r <= ST_HOLD;
			cause_r <= CAUSE_POR;
			cnt_r <= MIN_RESET_CYC;
		end else if (CE) begin
			state_r <= state_nxt;
			cause_r <= cause_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Core, pin and port controls
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			CORE_RST <= 1'b1;
			RST_PIN_N_OUT <= 1'b0;
			RST_PIN_N_OE_N <= 1'b0;
			PORT_FORCE <= 1'b1;
			PORT_LATCH <= PORT_RESET_VAL;
			WEAK_PULLUP_EN <= 1'b1;
		end else if (CE) begin
			CORE_RST <= (state_nxt != ST_RUN);
			RST_PIN_N_OUT <= 1'b0;
			RST_PIN_N_OE_N <= ~drive_nxt;
			PORT_FORCE <= (state_nxt != ST_RUN);
			PORT_LATCH <= PORT_RESET_VAL;
			WEAK_PULLUP_EN <= 1'b1;
		end
	end

	// Exit strobe
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			EXIT <= '0;
		end else if (CE) begin
			EXIT.start <= exit_now;
			EXIT.wdt_enable <= exit_now;
			EXIT.clk_internal <= exit_now;
			EXIT.pc <= RESET_PC;
		end
	end

	// Cause to flag position
	always_comb begin
		flag_set = 8'h00;
		case (cause_r)
			CAUSE_POR: flag_set[SRC_POR] = 1'b1;
			CAUSE_SUPPLY: flag_set[SRC_POR] = 1'b1;
			CAUSE_PIN: flag_set[SRC_PIN] = 1'b1;
			CAUSE_MCD: flag_set[SRC_MCD] = 1'b1;
			CAUSE_COMP: flag_set[SRC_COMP] = 1'b1;
			CAUSE_WDT: flag_set[SRC_WDT] = 1'b1;
			CAUSE_FLASH: flag_set[SRC_FERR] = 1'b1;
			CAUSE_SW: flag_set[SRC_SW] = 1'b1;
			default: flag_set = 8'h00;
		endcase
	end

	// Cause flags captured on release
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			por_f_r <= 1'b0;
			pin_f_r <= 1'b0;
			mcd_f_r <= 1'b0;
			comp_f_r <= 1'b0;
			wdt_f_r <= 1'b0;
			ferr_f_r <= 1'b0;
			sw_f_r <= 1'b0;
		end else if (CE && exit_now) begin
			por_f_r <= flag_set[SRC_POR];
			pin_f_r <= flag_set[SRC_PIN];
			mcd_f_r <= flag_set[SRC_MCD];
			comp_f_r <= flag_set[SRC_COMP];
			wdt_f_r <= flag_set[SRC_WDT];
			ferr_f_r <= flag_set[SRC_FERR];
			sw_f_r <= flag_set[SRC_SW];
		end
	end

	// Supply monitor enable and selection, untouched by device resets
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			mon_en_r <= 1'b1;
			mon_sel_r <= 1'b1;
		end else if (CE) begin
			if (wr_mon) begin
				mon_en_r <= AVS_WRITEDATA[MON_EN_BIT];
			end
			if (wr_src) begin
				mon_sel_r <= AVS_WRITEDATA[SRC_MON_SEL];
			end
		end
	end

	// Detector and comparator enables, cleared by any reset
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			mcd_en_r <= 1'b0;
			comp_en_r <= 1'b0;
		end else if (CE) begin
			if (state_r != ST_RUN) begin
				if (exit_now) begin
					mcd_en_r <= 1'b0;
					comp_en_r <= 1'b0;
				end
			end else if (wr_src) begin
				mcd_en_r <= AVS_WRITEDATA[SRC_MCD];
				comp_en_r <= AVS_WRITEDATA[SRC_COMP];
			end
		end
	end

	// Software reset request
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sw_req_r <= 1'b0;
		end else if (CE) begin
			if (wr_src && AVS_WRITEDATA[SRC_SW] && state_r == ST_RUN) begin
				sw_req_r <= 1'b1;
			end else if (state_r != ST_RUN) begin
				sw_req_r <= 1'b0;
			end
		end
	end

	// Flash request gating
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			FLASH_ANS <= '0;
		end else if (CE) begin
			FLASH_ANS.op <= FLASH_REQ.op;
			if (FLASH_REQ.op == FOP_WRITE || FLASH_REQ.op == FOP_ERASE) begin
				FLASH_ANS.grant <= FLASH_REQ.valid & flash_legal & mon_en_r & (state_r == ST_RUN);
			end else begin
				FLASH_ANS.grant <= FLASH_REQ.valid & flash_legal & (state_r == ST_RUN);
			end
		end
	end

	// Read mux
	always_comb begin
		rd_nxt = ZERO_WORD;
		case (AVS_ADDRESS)
			REG_SRC: begin
				rd_nxt[SRC_MON_SEL] = mon_sel_r;
				rd_nxt[SRC_POR] = por_f_r;
				rd_nxt[SRC_MCD] = mcd_f_r;
				rd_nxt[SRC_COMP] = comp_f_r;
				rd_nxt[SRC_SW] = sw_f_r;
				rd_nxt[SRC_FERR] = ferr_f_r;
				rd_nxt[SRC_WDT] = wdt_f_r;
				rd_nxt[SRC_PIN] = pin_f_r;
			end
			REG_MON: begin
				rd_nxt[MON_EN_BIT] = mon_en_r;
			end
			REG_LIVE: begin
				rd_nxt[LIVE_SUPPLY_LOW] = SUPPLY_LOW;
				rd_nxt[LIVE_COMP_BELOW] = COMP_BELOW;
				rd_nxt[LIVE_PIN_LOW] = ~RST_PIN_N_IN;
				rd_nxt[LIVE_IN_RESET] = CORE_RST;
				rd_nxt[LIVE_PIN_DRIVE] = ~RST_PIN_N_OE_N;
			end
			default: begin
				rd_nxt = ZERO_WORD;
			end
		endcase
	end

	// Avalon slave: one wait cycle per access
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= ZERO_WORD;
		end else if (CE) begin
			if (bus_req && AVS_WAITREQUEST) begin
				AVS_WAITREQUEST <= 1'b0;
				AVS_READDATA <= AVS_READ ? rd_nxt : ZERO_WORD;
			end else begin
				AVS_WAITREQUEST <= 1'b1;
			end
		end
	end
endmodule : rsc_reset_source_controller

// >>> verification/rsc_reset_properties.sv
// Port checker for the reset source controller
`timescale 1ns/100ps
module rsc_reset_properties (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic RST_PIN_N_IN,
	input wire logic RST_PIN_N_OUT,
	input wire logic RST_PIN_N_OE_N,
	input wire logic WDT_TIMEOUT,
	input wire rsc_pkg::rsc_flash_req_t FLASH_REQ,
	input wire rsc_pkg::rsc_flash_ans_t FLASH_ANS,
	input wire logic CORE_RST,
	input wire logic PORT_FORCE,
	input wire logic [7:0] PORT_LATCH,
	input wire logic WEAK_PULLUP_EN,
	input wire rsc_pkg::rsc_exit_t EXIT
);
	import rsc_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	a_port_ones: assert property (PORT_LATCH == PORT_RESET_VAL && WEAK_PULLUP_EN)
		else $error("port latch or pullup wrong");
	a_force_tracks: assert property (PORT_FORCE == CORE_RST)
		else $error("port force apart from reset");
	a_exit_pulse: assert property ($fell(CORE_RST) |-> EXIT.start && EXIT.wdt_enable
		&& EXIT.clk_internal && EXIT.pc == RESET_PC)
		else $error("exit pulse missing");
	a_pin_drive: assert property (!RST_PIN_N_OE_N |-> CORE_RST && !RST_PIN_N_OUT)
		else $error("pin driven outside reset");
	a_pin_enter: assert property (!CORE_RST && !RST_PIN_N_IN |=> CORE_RST)
		else $error("pin low ignored");
	a_wdt_enter: assert property (!CORE_RST && WDT_TIMEOUT |=> CORE_RST)
		else $error("watchdog ignored");
	a_flash_bad: assert property (!CORE_RST && FLASH_REQ.valid
		&& (FLASH_REQ.addr > USER_TOP || FLASH_REQ.secure_block) |=> CORE_RST)
		else $error("flash error ignored");
	a_grant_legal: assert property (FLASH_ANS.grant |-> $past(FLASH_REQ.valid)
		&& $past(FLASH_REQ.addr) <= USER_TOP && !$past(FLASH_REQ.secure_block) && !$past(CORE_RST))
		else $error("bad flash grant");
	a_reset_min: assert property ($rose(CORE_RST) |=> CORE_RST[*8])
		else $error("reset too short");
	cover property ($fell(CORE_RST));
	cover property (FLASH_ANS.grant);
	cover property (!RST_PIN_N_OE_N && CORE_RST);
endmodule : rsc_reset_properties

bind rsc_reset_source_controller rsc_reset_properties u_props (.*);

// >>> verification/rsc_ext_rail.sv
// External reset pin circuitry with pull-up
`timescale 1ns/100ps
module rsc_ext_rail (
	input wire logic oe_n,
	input wire logic hold_low,
	output logic pin_n
);
	// Pull-up unless either side drives low
	assign pin_n = oe_n && !hold_low;
endmodule : rsc_ext_rail

// >>> verification/tb.sv
// Self-checking bench for the reset source controller
`timescale 1ns/100ps
module tb;
	import rsc_pkg::*;
	logic CLK, SYS_RST, CE, AVS_READ, AVS_WRITE, SUPPLY_LOW, MCD_TIMEOUT, COMP_BELOW, WDT_TIMEOUT, ext_low;
	logic RST_PIN_N_IN, AVS_WAITREQUEST, RST_PIN_N_OUT, RST_PIN_N_OE_N, CORE_RST, PORT_FORCE, WEAK_PULLUP_EN;
	logic [ADDR_W-1:0] AVS_ADDRESS;
	logic [DATA_W-1:0] AVS_WRITEDATA, AVS_READDATA, rd;
	logic [3:0] AVS_BYTEENABLE;
	logic [7:0] PORT_LATCH;
	rsc_flash_req_t FLASH_REQ;
	rsc_flash_ans_t FLASH_ANS;
	rsc_exit_t EXIT;
	int failures, checks_done;
	// Flags expected per cause: wdt, pin, mcd, comp, sw, flash, supply
	logic [DATA_W-1:0] exps [7] = '{32'h0000_0041, 32'h0000_0081, 32'h0000_0005, 32'h0000_0009,
		32'h0000_0011, 32'h0000_0021, 32'h0000_0003};

	rsc_reset_source_controller dut (.*);
	rsc_ext_rail u_rail (.oe_n(RST_PIN_N_OE_N), .hold_low(ext_low), .pin_n(RST_PIN_N_IN));

	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end

	task chk32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: word %h want %h", $time, got, exp);
		end
	endtask : chk32

	task chk1(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: bit %b want %b", $time, got, exp);
		end
	endtask : chk1

	task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		do begin
			@(posedge CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		if (AVS_WAITREQUEST !== 1'b0) begin
			failures++;
			$display("unexpected at %0t: no bus answer", $time);
		end
		rd = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask : acc

	task wait_rst(input logic v, input int lim);
		int n;
		n = 0;
		@(negedge CLK);
		while (CORE_RST !== v && n < lim) begin
			@(negedge CLK);
			n++;
		end
		chk1(CORE_RST, v);
	endtask : wait_rst

	task fl(input rsc_flash_op_t op, input logic [15:0] a, input logic g);
		@(posedge CLK);
		FLASH_REQ <= '{1'b1, op, a, 1'b0};
		@(posedge CLK);
		FLASH_REQ.valid <= 1'b0;
		@(negedge CLK);
		chk1(FLASH_ANS.grant, g);
		chk32(32'(FLASH_ANS.op), 32'(op));
	endtask : fl

	task test_done;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	initial begin
		repeat (12000) @(posedge CLK);
		failures++;
		test_done;
	end

	initial begin
		failures = 0;
		checks_done = 0;
		{SYS_RST, CE, AVS_BYTEENABLE} = 6'h3F;
		{AVS_READ, AVS_WRITE, SUPPLY_LOW, MCD_TIMEOUT, COMP_BELOW, WDT_TIMEOUT, ext_low} = 7'h00;
		AVS_ADDRESS = REG_SRC;
		AVS_WRITEDATA = ZERO_WORD;
		FLASH_REQ = '0;
		repeat (4) @(posedge CLK);
		SYS_RST <= 1'b0;
		@(negedge CLK);
		chk1(RST_PIN_N_OE_N, 1'b0);
		wait_rst(1'b0, 3100);
		acc(0, REG_SRC, ZERO_WORD);
		chk32(rd, 32'h0000_0003);
		acc(0, REG_MON, ZERO_WORD);
		chk32(rd, 32'h0000_0001);
		for (int i = 0; i < 7; i++) begin
			if (i inside {[2:4]})
				acc(1, REG_SRC, i == 2 ? 32'h0000_0005 : i == 3 ? 32'h0000_0009 : 32'h0000_0011);
			@(posedge CLK);
			case (i)
				0: WDT_TIMEOUT <= 1'b1;
				1: ext_low <= 1'b1;
				2: MCD_TIMEOUT <= 1'b1;
				3: COMP_BELOW <= 1'b1;
				5: FLASH_REQ <= '{1'b1, FOP_FETCH, 16'h2000, 1'b0};
				6: SUPPLY_LOW <= 1'b1;
				default: ;
			endcase
			@(posedge CLK);
			WDT_TIMEOUT <= 1'b0;
			MCD_TIMEOUT <= 1'b0;
			FLASH_REQ.valid <= 1'b0;
			wait_rst(1'b1, 20);
			chk1(RST_PIN_N_OE_N, i != 6);
			repeat (15) @(posedge CLK);
			ext_low <= 1'b0;
			COMP_BELOW <= 1'b0;
			SUPPLY_LOW <= 1'b0;
			wait_rst(1'b0, 100);
			acc(0, REG_SRC, ZERO_WORD);
			chk32(rd, exps[i]);
		end
		fl(FOP_WRITE, 16'h0100, 1'b1);
		acc(1, REG_SRC, ZERO_WORD);
		acc(1, REG_MON, ZERO_WORD);
		fl(FOP_ERASE, 16'h0100, 1'b0);
		fl(FOP_READ, 16'h0100, 1'b1);
		@(posedge CLK);
		SUPPLY_LOW <= 1'b1;
		repeat (20) @(posedge CLK);
		SUPPLY_LOW <= 1'b0;
		wait_rst(1'b0, 1);
		acc(1, REG_SRC, 32'h0000_0010);
		wait_rst(1'b1, 20);
		wait_rst(1'b0, 100);
		acc(0, REG_MON, ZERO_WORD);
		chk32(rd, ZERO_WORD);
		acc(0, REG_SRC, ZERO_WORD);
		chk32(rd, 32'h0000_0010);
		acc(1, REG_MON, 32'h0000_0001);
		acc(1, REG_SRC, 32'h0000_0001);
		acc(1, 4'hC, 32'h0000_00FF);
		acc(0, 4'hC, ZERO_WORD);
		chk32(rd, ZERO_WORD);
		acc(0, REG_SRC, ZERO_WORD);
		chk32(rd, 32'h0000_0011);
		test_done;
	end
endmodule : tb
